// file: logic/csf_pkg.sv
`default_nettype none
package csf_pkg;

	// ------------------------------------------------------------
	// Register byte offsets on the APB port
	// ------------------------------------------------------------
	localparam logic [7:0] STATUS_OFFSET = 8'h00;
	localparam logic [7:0] INT_STATUS_OFFSET = 8'h04;
	localparam logic [7:0] INT_MASK_OFFSET = 8'h08;
	localparam logic [7:0] LAST_RESULT_OFFSET = 8'h0C;

	// ------------------------------------------------------------
	// Status register field positions
	// ------------------------------------------------------------
	localparam int CARRY_BIT = 0;
	localparam int HALF_CARRY_BIT = 1;
	localparam int ZERO_BIT = 2;
	localparam int OVERFLOW_BIT = 3;
	localparam int POWER_DOWN_BIT = 4;
	localparam int TIMEOUT_BIT = 5;
	localparam int ARITH_FLAG_W = 4;

	// ------------------------------------------------------------
	// Interrupt event positions
	// ------------------------------------------------------------
	localparam int EVT_TIMEOUT_BIT = 0;
	localparam int EVT_HALT_BIT = 1;
	localparam int EVT_OVERFLOW_BIT = 2;
	localparam int EVT_W = 3;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [3:0] ARITH_FLAGS_RESET = 4'h0;
	localparam logic [2:0] INT_MASK_RESET = 3'h0;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam int RESET_SYNC_STAGES = 2;

	// ------------------------------------------------------------
	// Operation classes reported by the execution logic
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CSF_OP_ADD,
		CSF_OP_ADD_CARRY,
		CSF_OP_SUB,
		CSF_OP_SUB_CARRY,
		CSF_OP_LOGIC,
		CSF_OP_ROT_LEFT_CARRY,
		CSF_OP_ROT_RIGHT_CARRY
	} csf_op_type;

endpackage
`default_nettype wire

// file: logic/csf_reset_sync.sv
`timescale 1ns/1ps
`default_nettype none
module csf_reset_sync #(
	parameter int STAGES = csf_pkg::RESET_SYNC_STAGES
) (
	// Clock and raw reset
	input wire logic clk,
	input wire logic rst_b,
	// Released copy
	output logic syncRst_b
);

	logic [STAGES-1:0] chain_q;

	// ------------------------------------------------------------
	// Release chain
	// ------------------------------------------------------------
	// Assert at once, release only after the chain fills
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			chain_q <= '0;
		end else begin
			chain_q <= {chain_q[STAGES-2:0], 1'b1};
		end
	end

	assign syncRst_b = chain_q[STAGES-1];

endmodule
`default_nettype wire

// file: logic/csf_flag_calc.sv
`timescale 1ns/1ps
`default_nettype none
module csf_flag_calc #(
	parameter int WIDTH = 8
) (
	// Operation
	input wire csf_pkg::csf_op_type opKind,
	input wire logic [WIDTH-1:0] opA,
	input wire logic [WIDTH-1:0] opB,
	input wire logic carryIn,
	// Result and flags
	output logic [WIDTH-1:0] result,
	output logic carryOut,
	output logic halfCarryOut,
	output logic overflowOut,
	output logic zeroOut,
	// Which flags this operation touches
	output logic updArith,
	output logic updZero,
	output logic updCarry
);

	localparam int NIB = WIDTH / 2;

	wire isSub = (opKind == csf_pkg::CSF_OP_SUB) || (opKind == csf_pkg::CSF_OP_SUB_CARRY);
	wire isAdd = (opKind == csf_pkg::CSF_OP_ADD) || (opKind == csf_pkg::CSF_OP_ADD_CARRY);
	wire isRotL = opKind == csf_pkg::CSF_OP_ROT_LEFT_CARRY;
	wire isRotR = opKind == csf_pkg::CSF_OP_ROT_RIGHT_CARRY;

	// ------------------------------------------------------------
	// Adder: subtraction as a + ~b + 1 so carry means no borrow
	// ------------------------------------------------------------
	wire [WIDTH-1:0] addend = isSub ? ~opB : opB;
	wire cin = (opKind == csf_pkg::CSF_OP_SUB) ? 1'b1 :
		((opKind == csf_pkg::CSF_OP_ADD) ? 1'b0 : carryIn);
	wire [NIB:0] lowSum = {1'b0, opA[NIB-1:0]} + {1'b0, addend[NIB-1:0]} + {{NIB{1'b0}}, cin};
	wire [WIDTH-1:0] lowMsbSum = {1'b0, opA[WIDTH-2:0]} + {1'b0, addend[WIDTH-2:0]}
		+ {{(WIDTH-1){1'b0}}, cin};
	wire [WIDTH:0] fullSum = {1'b0, opA} + {1'b0, addend} + {{WIDTH{1'b0}}, cin};

	// Result select; logic results arrive already formed in opA
	assign result = (isAdd || isSub) ? fullSum[WIDTH-1:0] :
		isRotL ? {opA[WIDTH-2:0], carryIn} :
		isRotR ? {carryIn, opA[WIDTH-1:1]} : opA;

	// (RULE_06) carry or no borrow
	// (RULE_05) rotate shifts out into carry
	assign carryOut = isRotL ? opA[WIDTH-1] : (isRotR ? opA[0] : fullSum[WIDTH]);
	// (RULE_04) nibble carry or no borrow
	assign halfCarryOut = lowSum[NIB];
	// (RULE_02) carry in differs from out
	assign overflowOut = lowMsbSum[WIDTH-1] ^ fullSum[WIDTH];
	// (RULE_03) zero result
	assign zeroOut = ~|result;

	assign updArith = isAdd || isSub;
	assign updZero = isAdd || isSub || (opKind == csf_pkg::CSF_OP_LOGIC);
	assign updCarry = isAdd || isSub || isRotL || isRotR;

endmodule
`default_nettype wire

// file: logic/csf_status_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RULE_01) Power-down flag: cleared at power-up or watchdog clear, set by halt.
// (RULE_02) Overflow set when carry into MSB differs from carry out, else cleared.
// (RULE_03) Zero flag set when arithmetic or logic result is zero, else cleared.
// (RULE_04) Half carry: low nibble carry on add, no nibble borrow on subtract.
// (RULE_05) Rotate through carry loads shifted-out bit into carry, old carry enters.
// (RULE_06) Carry set on add carry-out or subtract with no borrow, else cleared.
// (RULE_07) Timeout flag set by watchdog timeout; cleared by power-up, clear, halt.
// (RULE_08) Software writes change only arithmetic flags, never timeout or power-down.
// (RULE_09) Top two bits read zero; system flags zero after power-on reset.
module csf_status_top #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Execution unit
	input wire logic opValid,
	input wire csf_pkg::csf_op_type opKind,
	input wire logic [WIDTH-1:0] opA,
	input wire logic [WIDTH-1:0] opB,
	output logic [WIDTH-1:0] opResult,
	// System events
	input wire logic watchdogClearExec,
	input wire logic haltExec,
	input wire logic watchdogTimeoutEvt,
	// Flag view and interrupt
	output logic [7:0] statusFlags,
	output logic irq
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic syncRst_b;

	csf_reset_sync #(
		.STAGES(csf_pkg::RESET_SYNC_STAGES)
	) uResetSync (
		.clk(clk),
		.rst_b(rst_b),
		.syncRst_b(syncRst_b)
	);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [3:0] arithFlags_q;
	logic [3:0] arithFlags_d;
	logic timeoutFlag_q;
	logic timeoutFlag_d;
	logic powerDownFlag_q;
	logic powerDownFlag_d;
	logic [csf_pkg::EVT_W-1:0] intStatus_q;
	logic [csf_pkg::EVT_W-1:0] intStatus_d;
	logic [csf_pkg::EVT_W-1:0] intMask_q;
	logic [csf_pkg::EVT_W-1:0] intMask_d;
	logic [WIDTH-1:0] result_q;
	logic [WIDTH-1:0] result_d;

	// Result reset value, sized to the datapath
	localparam logic [WIDTH-1:0] RESULT_RST = WIDTH'(csf_pkg::RESULT_RESET);

	// ------------------------------------------------------------
	// Flag calculation
	// ------------------------------------------------------------
	logic [WIDTH-1:0] calcResult;
	logic calcCarry;
	logic calcHalfCarry;
	logic calcOverflow;
	logic calcZero;
	logic updArith;
	logic updZero;
	logic updCarry;

	csf_flag_calc #(
		.WIDTH(WIDTH)
	) uFlagCalc (
		.opKind(opKind),
		.opA(opA),
		.opB(opB),
		.carryIn(arithFlags_q[csf_pkg::CARRY_BIT]),
		.result(calcResult),
		.carryOut(calcCarry),
		.halfCarryOut(calcHalfCarry),
		.overflowOut(calcOverflow),
		.zeroOut(calcZero),
		.updArith(updArith),
		.updZero(updZero),
		.updCarry(updCarry)
	);

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	// Single-cycle access phase, so pready may be tied high
	wire apbAccess = psel && penable;
	wire hitStatus = paddr == csf_pkg::STATUS_OFFSET;
	wire hitIntStatus = paddr == csf_pkg::INT_STATUS_OFFSET;
	wire hitIntMask = paddr == csf_pkg::INT_MASK_OFFSET;
	wire hitResult = paddr == csf_pkg::LAST_RESULT_OFFSET;
	wire hitAny = hitStatus || hitIntStatus || hitIntMask || hitResult;
	wire wrStatus = apbAccess && pwrite && hitStatus;
	wire wrIntMask = apbAccess && pwrite && hitIntMask;
	wire rdIntStatus = apbAccess && !pwrite && hitIntStatus;

	assign pready = 1'b1;
	assign pslverr = apbAccess && !hitAny;

	// ------------------------------------------------------------
	// Arithmetic flag update
	// ------------------------------------------------------------
	// Execution wins over a same-cycle software write, per flag it touches
	wire [3:0] execMask = {updArith, updZero, updArith, updCarry};
	wire [3:0] execVal = {calcOverflow, calcZero, calcHalfCarry, calcCarry};
	// (RULE_08) software loads arithmetic flags
	wire [3:0] swVal = wrStatus ? pwdata[3:0] : arithFlags_q;
	// (RULE_02) overflow, zero, half carry, carry
	// (RULE_05) rotate carry update
	assign arithFlags_d = opValid ? ((execVal & execMask) | (swVal & ~execMask)) : swVal;

	// ------------------------------------------------------------
	// System flag update
	// ------------------------------------------------------------
	// Timeout set wins over a same-cycle clear so no event is lost
	// (RULE_07) timeout set and clear
	assign timeoutFlag_d = watchdogTimeoutEvt ? 1'b1 :
		((watchdogClearExec || haltExec) ? 1'b0 : timeoutFlag_q);
	// (RULE_01) halt sets, watchdog clear clears
	assign powerDownFlag_d = haltExec ? 1'b1 :
		(watchdogClearExec ? 1'b0 : powerDownFlag_q);

	// ------------------------------------------------------------
	// Interrupt status, mask and result capture
	// ------------------------------------------------------------
	wire [csf_pkg::EVT_W-1:0] events;
	assign events[csf_pkg::EVT_TIMEOUT_BIT] = watchdogTimeoutEvt;
	assign events[csf_pkg::EVT_HALT_BIT] = haltExec;
	assign events[csf_pkg::EVT_OVERFLOW_BIT] = opValid && updArith && calcOverflow;

	// Read clears, but an event in the same cycle survives
	assign intStatus_d = (intStatus_q & ~{csf_pkg::EVT_W{rdIntStatus}}) | events;
	assign intMask_d = wrIntMask ? pwdata[csf_pkg::EVT_W-1:0] : intMask_q;
	assign result_d = opValid ? calcResult : result_q;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// (RULE_09) system flags zero on power-on
	always_ff @(posedge clk or negedge syncRst_b) begin
		if (!syncRst_b) begin
			timeoutFlag_q <= 1'b0;
			powerDownFlag_q <= 1'b0;
		end else begin
			timeoutFlag_q <= timeoutFlag_d;
			powerDownFlag_q <= powerDownFlag_d;
		end
	end

	// Arithmetic flags are undefined after power-on; zero is chosen
	always_ff @(posedge clk or negedge syncRst_b) begin
		if (!syncRst_b) begin
			arithFlags_q <= csf_pkg::ARITH_FLAGS_RESET;
			result_q <= RESULT_RST;
		end else begin
			arithFlags_q <= arithFlags_d;
			result_q <= result_d;
		end
	end

	// Interrupt bookkeeping
	always_ff @(posedge clk or negedge syncRst_b) begin
		if (!syncRst_b) begin
			intStatus_q <= '0;
			intMask_q <= csf_pkg::INT_MASK_RESET;
		end else begin
			intStatus_q <= intStatus_d;
			intMask_q <= intMask_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// (RULE_09) top two bits read zero
	assign statusFlags = {2'b00, timeoutFlag_q, powerDownFlag_q, arithFlags_q};
	assign opResult = result_q;
	assign irq = |(intStatus_q & intMask_q);

	// Read mux; unused upper bits read zero
	wire [31:0] rdStatus = {24'h000000, statusFlags};
	wire [31:0] rdIntStatus_w = {{(32-csf_pkg::EVT_W){1'b0}}, intStatus_q};
	wire [31:0] rdIntMask_w = {{(32-csf_pkg::EVT_W){1'b0}}, intMask_q};
	wire [31:0] rdResult = {{(32-WIDTH){1'b0}}, result_q};
	assign prdata = hitStatus ? rdStatus :
		hitIntStatus ? rdIntStatus_w :
		hitIntMask ? rdIntMask_w :
		hitResult ? rdResult : 32'h00000000;

endmodule
`default_nettype wire

// file: verif/csf_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Status flag checker
// ----------------------------------------
module csf_status_monitor #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	// Execution
	input wire logic opValid,
	input wire csf_pkg::csf_op_type opKind,
	input wire logic [WIDTH-1:0] opA,
	input wire logic [WIDTH-1:0] opB,
	input wire logic [WIDTH-1:0] opResult,
	// Events and flags
	input wire logic watchdogClearExec,
	input wire logic haltExec,
	input wire logic watchdogTimeoutEvt,
	input wire logic [7:0] statusFlags
);
	logic [WIDTH:0] addSum;
	logic [4:0] nibSum;
	logic addOv, isAdd, isRotL, sysEvt, stWr, opMsb;
	// Reference sums for a plain add
	assign addSum = {1'h0, opA} + {1'h0, opB};
	assign nibSum = {1'h0, opA[3:0]} + {1'h0, opB[3:0]};
	assign addOv = (opA[WIDTH-1] == opB[WIDTH-1]) && (addSum[WIDTH-1] != opA[WIDTH-1]);
	assign opMsb = opA[WIDTH-1];
	assign isAdd = opValid && (opKind == csf_pkg::CSF_OP_ADD);
	assign isRotL = opValid && (opKind == csf_pkg::CSF_OP_ROT_LEFT_CARRY);
	assign sysEvt = haltExec | watchdogClearExec | watchdogTimeoutEvt;
	assign stWr = psel & penable & pwrite & (paddr == csf_pkg::STATUS_OFFSET);
	// Raw reset only; flags sit at zero while the synced copy lags
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_top_zero; statusFlags[7:6] == 2'h0; endproperty
	property p_to_set; watchdogTimeoutEvt |=> statusFlags[5]; endproperty
	property p_to_clr; (haltExec | watchdogClearExec) & !watchdogTimeoutEvt |=> !statusFlags[5];
	endproperty
	property p_pd_set; haltExec |=> statusFlags[4]; endproperty
	property p_pd_clr; watchdogClearExec & !haltExec |=> !statusFlags[4]; endproperty
	property p_sys_hold; stWr & !sysEvt |=> $stable(statusFlags[5:4]); endproperty
	property p_add_c; isAdd |=> statusFlags[0] == $past(addSum[WIDTH]); endproperty
	property p_add_ac; isAdd |=> statusFlags[1] == $past(nibSum[4]); endproperty
	property p_add_ov; isAdd |=> statusFlags[3] == $past(addOv); endproperty
	property p_add_z; isAdd |=> statusFlags[2] == $past(addSum[WIDTH-1:0] == '0); endproperty
	property p_rot_l; isRotL |=> statusFlags[0] == $past(opMsb) && opResult[0] == $past(statusFlags[0]);
	endproperty
	a_top_zero: assert property (p_top_zero) else $error("top bits set");
	a_to_set: assert property (p_to_set) else $error("timeout not set");
	a_to_clr: assert property (p_to_clr) else $error("timeout not cleared");
	a_pd_set: assert property (p_pd_set) else $error("power-down not set");
	a_pd_clr: assert property (p_pd_clr) else $error("power-down not cleared");
	a_sys_hold: assert property (p_sys_hold) else $error("write hit system flags");
	a_add_c: assert property (p_add_c) else $error("carry wrong");
	a_add_ac: assert property (p_add_ac) else $error("half carry wrong");
	a_add_ov: assert property (p_add_ov) else $error("overflow wrong");
	a_add_z: assert property (p_add_z) else $error("zero wrong");
	a_rot_l: assert property (p_rot_l) else $error("rotate carry wrong");
	c_add: cover property (isAdd);
	c_halt: cover property (haltExec);
	c_wr: cover property (stWr);
endmodule
bind csf_status_top csf_status_monitor #(.WIDTH(WIDTH)) csf_status_monitor_i (.clk(clk),
	.rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.opValid(opValid), .opKind(opKind), .opA(opA), .opB(opB), .opResult(opResult),
	.watchdogClearExec(watchdogClearExec), .haltExec(haltExec),
	.watchdogTimeoutEvt(watchdogTimeoutEvt), .statusFlags(statusFlags));
`default_nettype wire

// file: verif/csf_exec_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Execution unit stand-in
// ----------------------------------------
module csf_exec_model #(
	parameter int WIDTH = 8
) (
	// Clock
	input wire logic clk,
	// Operation
	output logic opValid,
	output csf_pkg::csf_op_type opKind,
	output logic [WIDTH-1:0] opA,
	output logic [WIDTH-1:0] opB
);
	// Idle until the first operation
	initial begin
		opValid = 1'h0;
		opKind = csf_pkg::CSF_OP_ADD;
		opA = '0;
		opB = '0;
	end
	// One-cycle operation; operands scrambled after so stale values never help
	task automatic issue(input csf_pkg::csf_op_type k, input logic [WIDTH-1:0] a, b);
		@(posedge clk);
		opValid <= 1'h1;
		opKind <= k;
		opA <= a;
		opB <= b;
		@(posedge clk);
		opValid <= 1'h0;
		opA <= ~a;
		opB <= ~b;
	endtask
endmodule
`default_nettype wire

// file: verif/cpu_status_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
// ----------------------------------------
// Status flag bench
// ----------------------------------------
module cpu_status_flags_tb;
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, opValid, irq, err;
	logic [7:0] paddr, opA, opB, opResult, statusFlags;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] evt;
	csf_pkg::csf_op_type opKind;
	int miscompares, checked;
	csf_status_top csf_status_top_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .opValid(opValid), .opKind(opKind), .opA(opA), .opB(opB),
		.opResult(opResult), .watchdogClearExec(evt[0]), .haltExec(evt[1]),
		.watchdogTimeoutEvt(evt[2]), .statusFlags(statusFlags), .irq(irq));
	csf_exec_model csf_exec_model_i (.clk(clk), .opValid(opValid), .opKind(opKind),
		.opA(opA), .opB(opB));
	// 25 ns clock
	always #12.5 clk = ~clk;
	// Bus cycle; answer taken at the edge that samples pready high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		evt[i] <= 1'h1;
		@(posedge clk);
		evt <= 3'h0;
		@(negedge clk);
	endtask
	task automatic op(input csf_pkg::csf_op_type k, input logic [7:0] a, b, res,
		input logic [3:0] fl);
		csf_exec_model_i.issue(k, a, b);
		@(negedge clk);
		`CHK(statusFlags[3:0], fl)
		`CHK(opResult, res)
	endtask
	task automatic t_arith;
		op(csf_pkg::CSF_OP_ADD, 8'h7F, 8'h01, 8'h80, 4'hA);
		op(csf_pkg::CSF_OP_ADD, 8'hFF, 8'h01, 8'h00, 4'h7);
		op(csf_pkg::CSF_OP_SUB, 8'h05, 8'h05, 8'h00, 4'h7);
		op(csf_pkg::CSF_OP_SUB, 8'h00, 8'h01, 8'hFF, 4'h0);
		op(csf_pkg::CSF_OP_ADD_CARRY, 8'h80, 8'h80, 8'h00, 4'hD);
		op(csf_pkg::CSF_OP_SUB_CARRY, 8'h10, 8'h01, 8'h0F, 4'h1);
	endtask
	task automatic t_rotate_logic;
		op(csf_pkg::CSF_OP_ROT_LEFT_CARRY, 8'h40, 8'h00, 8'h81, 4'h0);
		op(csf_pkg::CSF_OP_ROT_RIGHT_CARRY, 8'h01, 8'h00, 8'h00, 4'h1);
		op(csf_pkg::CSF_OP_LOGIC, 8'h00, 8'h5A, 8'h00, 4'h5);
		op(csf_pkg::CSF_OP_LOGIC, 8'h3C, 8'h00, 8'h3C, 4'h1);
	endtask
	task automatic t_system;
		pulse(2);
		`CHK(statusFlags[5:4], 2'h2)
		`CHK(irq, 1'h1)
		pulse(1);
		`CHK(statusFlags[5:4], 2'h1)
		apb(1'h1, csf_pkg::STATUS_OFFSET, 32'h3F);
		apb(1'h0, csf_pkg::STATUS_OFFSET, 32'h0);
		`CHK(rd, 32'h1F)
		apb(1'h0, csf_pkg::INT_STATUS_OFFSET, 32'h0);
		`CHK(rd, 32'h7)
		@(negedge clk);
		`CHK(irq, 1'h0)
		pulse(2);
		pulse(0);
		`CHK(statusFlags, 8'h0F)
		apb(1'h0, csf_pkg::LAST_RESULT_OFFSET, 32'h0);
		`CHK(rd, 32'h3C)
		apb(1'h0, 8'h10, 32'h0);
		`CHK({err, rd}, 33'h100000000)
	endtask
	task automatic complete_run;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Main sequence
	initial begin
		clk = 1'h0;
		{rst_b, psel, penable, pwrite, evt} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		`CHK(statusFlags, 8'h00)
		apb(1'h1, csf_pkg::INT_MASK_OFFSET, 32'h1);
		apb(1'h0, csf_pkg::INT_MASK_OFFSET, 32'h0);
		`CHK(rd, 32'h1)
		t_arith();
		`CHK(irq, 1'h0)
		t_rotate_logic();
		t_system();
		complete_run();
	end
	// Hang guard, well past the fewer than one hundred cycles needed
	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		complete_run();
	end
endmodule
`default_nettype wire
